// ===== inc/edct_pkg.sv
// Shared constants and types of the dual compare timer
package edct_pkg;
  localparam logic [15:0] ADDR_TIMER_CONTROL = 16'hFF69;
  localparam logic [15:0] ADDR_PRIMARY_COMPARE = 16'hFF0E;
  localparam logic [15:0] ADDR_SECONDARY_COMPARE = 16'hFF0F;
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [7:0] RESET_COMPARE = 8'h00;
  localparam logic [7:0] COUNT_TOP = 8'hFF;
  localparam logic [1:0] MODE_INTERVAL = 2'h0;
  localparam logic [1:0] MODE_CARRIER = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [2:0] CLK_DIV1 = 3'h0;
  localparam logic [2:0] CLK_DIV2 = 3'h1;
  localparam logic [2:0] CLK_DIV4 = 3'h2;
  localparam logic [2:0] CLK_DIV64 = 3'h3;
  localparam logic [2:0] CLK_DIV1024 = 3'h4;
  localparam logic [2:0] CLK_COMPANION = 3'h5;
  localparam int PRESCALE_W = 10;

  typedef struct packed {
    logic run_enable;
    logic [2:0] clock_select_field;
    logic [1:0] operating_mode_field;
    logic default_output_level;
    logic output_gate;
  } edct_control_s;

  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } edct_bus_s;
endpackage : edct_pkg

// ===== logic/edct_pin_ctl.sv
// Shared output pin: timer output merged with port latch and direction
module edct_pin_ctl (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic timer_out_in,
  input wire logic port_direction_bit_in,
  input wire logic port_latch_bit_in,
  output logic pin_out,
  output logic pin_oe_out
);
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pin_out <= 1'b0;
      pin_oe_out <= 1'b0;
    end
    else
    begin
      pin_out <= port_latch_bit_in | timer_out_in; // RL16
      pin_oe_out <= ~port_direction_bit_in; // RL16
    end
  end
endmodule : edct_pin_ctl

// ===== logic/edct_prescaler.sv
// Count clock selection: divided peripheral clock or companion timer edges
module edct_prescaler (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic [2:0] select_in,
  input wire logic companion_in,
  output logic tick_out
);
  logic [edct_pkg::PRESCALE_W-1:0] div;
  logic companion_q;
  logic next_tick;
  wire companion_rise = companion_in & ~companion_q;

  // One tick per period of the selected count clock
  always_comb
  begin
    case (select_in) // RL11
      edct_pkg::CLK_DIV1: next_tick = 1'b1;
      edct_pkg::CLK_DIV2: next_tick = div[0];
      edct_pkg::CLK_DIV4: next_tick = &div[1:0];
      edct_pkg::CLK_DIV64: next_tick = &div[5:0];
      edct_pkg::CLK_DIV1024: next_tick = &div;
      edct_pkg::CLK_COMPANION: next_tick = companion_rise;
      default: next_tick = 1'b0;
    endcase
  end

  // Divider restarts with each run so the first period is whole
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      div <= '0;
      companion_q <= 1'b0;
      tick_out <= 1'b0;
    end
    else
    begin
      div <= run_in ? div + 1'b1 : '0;
      companion_q <= companion_in;
      tick_out <= run_in & next_tick;
    end
  end
endmodule : edct_prescaler

// ===== logic/edct_timer.sv
// Eight-bit dual compare timer with mode register and shared output pin
// What this block does, and what software must do
// (RL1) Primary match raises interrupt, inverts output
// (RL2) Software changes primary compare only stopped
// (RL3) Reset clears mode and both compares
// (RL4) Secondary compare unused in interval mode
// (RL5) PWM secondary match inverts output, no interrupt
// (RL6) Carrier secondary match: interrupt and counter clear
// (RL7) Secondary write buffered, loaded at old match
// (RL8) Write colliding with match keeps old value
// (RL9) Software rewrites secondary before restart
// (RL10) Run bit clear stops, zeroes counter
// (RL11) Mode bits 6..4 select count clock
// (RL12) Mode bits 3..2 select operating mode
// (RL13) Bit 1 default level, bit 0 gate
// (RL14) Software keeps mode bits while running
// (RL15) Software starts companion timer first
// (RL16) Pin level depends on port bits
// (RL17) Interval primary match clears the counter
// (RL18) Match interval is compare plus one
// (RL19) Counter increments per tick, wraps at top
module edct_timer (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire edct_pkg::edct_bus_s cpu_bus_in,
  input wire logic companion_event_timer_in,
  input wire logic port_direction_bit_in,
  input wire logic port_latch_bit_in,
  output logic [7:0] cpu_rdata_out,
  output logic match_interrupt_out,
  output logic timer_output_pin_out,
  output logic timer_output_pin_oe_out
);
  edct_pkg::edct_control_s timer_control;
  logic [7:0] primary_compare;
  logic [7:0] secondary_compare;
  logic [7:0] secondary_buffer;
  logic secondary_pending;
  logic [7:0] count;
  logic flip;
  logic timer_out;
  logic tick;
  logic [7:0] next_count;
  logic [7:0] next_rdata;

  // Address decode
  wire sel_control = cpu_bus_in.addr == edct_pkg::ADDR_TIMER_CONTROL;
  wire sel_primary = cpu_bus_in.addr == edct_pkg::ADDR_PRIMARY_COMPARE;
  wire sel_secondary = cpu_bus_in.addr == edct_pkg::ADDR_SECONDARY_COMPARE;
  wire wr_control = cpu_bus_in.wr & sel_control;
  wire wr_primary = cpu_bus_in.wr & sel_primary;
  wire wr_secondary = cpu_bus_in.wr & sel_secondary;

  // Mode decode
  wire run = timer_control.run_enable;
  wire [1:0] op_mode = timer_control.operating_mode_field;
  wire is_interval = op_mode == edct_pkg::MODE_INTERVAL; // RL12
  wire is_pwm = op_mode == edct_pkg::MODE_PWM; // RL12
  wire is_carrier = op_mode == edct_pkg::MODE_CARRIER; // RL12

  // Match events, taken on the count clock tick
  wire match0 = count == primary_compare; // RL1
  wire match1 = count == secondary_compare;
  wire event0 = run & tick & match0; // RL1
  wire event1 = run & tick & match1 & (is_pwm | is_carrier); // RL4
  wire clear_count = (event0 & (is_interval | is_pwm)) | (event1 & is_carrier); // RL17 RL6
  wire invert = event0 | (event1 & is_pwm); // RL1 RL5
  wire raise_irq = event0 | (event1 & is_carrier); // RL1 RL5 RL6
  wire transfer = event1 & secondary_pending & ~wr_secondary; // RL7 RL8

  edct_prescaler u_prescaler (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .run_in(run),
    .select_in(timer_control.clock_select_field),
    .companion_in(companion_event_timer_in),
    .tick_out(tick)
  );

  edct_pin_ctl u_pin_ctl (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .timer_out_in(timer_out),
    .port_direction_bit_in(port_direction_bit_in),
    .port_latch_bit_in(port_latch_bit_in),
    .pin_out(timer_output_pin_out),
    .pin_oe_out(timer_output_pin_oe_out)
  );

  always_comb
  begin
    if (!run)
    begin
      next_count = 8'h00; // RL10
    end
    else if (clear_count)
    begin
      next_count = 8'h00; // RL17 RL18
    end
    else if (tick)
    begin
      next_count = count + 8'h01; // RL19
    end
    else
    begin
      next_count = count;
    end
  end

  always_comb
  begin
    if (sel_control)
    begin
      next_rdata = timer_control;
    end
    else if (sel_primary)
    begin
      next_rdata = primary_compare;
    end
    else if (sel_secondary)
    begin
      next_rdata = secondary_buffer;
    end
    else
    begin
      next_rdata = 8'h00;
    end
  end

  // Registers written by the CPU
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      timer_control <= edct_pkg::RESET_CONTROL; // RL3
      primary_compare <= edct_pkg::RESET_COMPARE; // RL3
    end
    else
    begin
      if (wr_control)
      begin
        timer_control <= cpu_bus_in.wdata;
      end
      if (wr_primary)
      begin
        primary_compare <= cpu_bus_in.wdata;
      end
    end
  end

  // Secondary compare: direct load while stopped, buffered while running
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      secondary_compare <= edct_pkg::RESET_COMPARE; // RL3
      secondary_buffer <= edct_pkg::RESET_COMPARE;
      secondary_pending <= 1'b0;
    end
    else if (wr_secondary && !run)
    begin
      secondary_compare <= cpu_bus_in.wdata;
      secondary_buffer <= cpu_bus_in.wdata;
      secondary_pending <= 1'b0;
    end
    else if (wr_secondary)
    begin
      secondary_buffer <= cpu_bus_in.wdata; // RL7
      secondary_pending <= 1'b1;
    end
    else if (transfer)
    begin
      secondary_compare <= secondary_buffer; // RL7
      secondary_pending <= 1'b0;
    end
  end

  // Counter, output flip-flop, interrupt pulse and read data
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      count <= 8'h00;
      flip <= 1'b0;
      timer_out <= 1'b0;
      match_interrupt_out <= 1'b0;
      cpu_rdata_out <= 8'h00;
    end
    else
    begin
      count <= next_count;
      if (!run)
      begin
        flip <= timer_control.default_output_level; // RL13
      end
      else if (invert)
      begin
        flip <= ~flip; // RL1 RL5
      end
      timer_out <= timer_control.output_gate & flip; // RL13
      match_interrupt_out <= raise_irq;
      cpu_rdata_out <= cpu_bus_in.rd ? next_rdata : cpu_rdata_out;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence carrier_hit_s;
    run && tick && is_carrier && match1;
  endsequence

  sequence irq_and_zero_s;
    match_interrupt_out && count == 8'h00;
  endsequence

  reset_values_a: assert property ($rose(rst_n_in) |-> // RL3
    timer_control == 8'h00 && primary_compare == 8'h00 && secondary_compare == 8'h00)
    else $error("registers not cleared by reset");

  stop_clear_a: assert property (!run |=> count == 8'h00) // RL10
    else $error("counter not zero while stopped");

  primary_irq_a: assert property (run && tick && match0 |=> match_interrupt_out) // RL1
    else $error("primary match gave no interrupt");

  primary_invert_a: assert property (run && tick && match0 |=> flip != $past(flip)) // RL1
    else $error("primary match did not invert output");

  interval_clear_a: assert property (run && tick && match0 && is_interval |=> count == 8'h00) // RL17
    else $error("interval match did not clear counter");

  interval_ignore_a: assert property (run && tick && is_interval && match1 && !match0 |=> // RL4
    !match_interrupt_out && $stable(flip))
    else $error("secondary match acted in interval mode");

  pwm_secondary_a: assert property (run && tick && is_pwm && match1 && !match0 |=> // RL5
    !match_interrupt_out && flip != $past(flip))
    else $error("pwm secondary match wrong");

  carrier_clear_a: assert property (carrier_hit_s |=> irq_and_zero_s) // RL6
    else $error("carrier match did not interrupt and clear");

  buffer_load_a: assert property (transfer |=> secondary_compare == $past(secondary_buffer)) // RL7
    else $error("buffered value not loaded at match");

  collide_keep_a: assert property (event1 && wr_secondary |=> $stable(secondary_compare)) // RL8
    else $error("colliding write changed compare");

  count_wrap_a: assert property (run && tick && !clear_count && count == edct_pkg::COUNT_TOP |=> // RL19
    count == 8'h00)
    else $error("counter did not wrap");

  gate_off_a: assert property (!timer_control.output_gate |=> !timer_out) // RL13
    else $error("gated output not low");

  sequence pwm_primary_hit_s;
    run && tick && is_pwm && match0;
  endsequence

  pwm_clear_a: assert property (pwm_primary_hit_s |=> count == 8'h00) // RL12
    else $error("pwm primary match did not clear counter");

  irq_cause_a: assert property (!(run && tick && (match0 || (match1 && is_carrier))) |=> // RL4 RL5
    !match_interrupt_out)
    else $error("interrupt without a match");

  stop_level_a: assert property (!run |=> flip == $past(timer_control.default_output_level)) // RL13
    else $error("stopped output not at default level");

  gate_on_a: assert property (timer_control.output_gate |=> timer_out == $past(flip)) // RL13
    else $error("enabled output does not follow flip");

  count_step_a: assert property (run && tick && !match0 && !match1 |=> count == $past(count) + 8'h01) // RL19
    else $error("counter did not step on tick");

  count_hold_a: assert property (run && !tick |=> $stable(count)) // RL19
    else $error("counter moved without tick");

  pin_level_a: assert property (1'b1 |=> // RL16
    timer_output_pin_out == ($past(port_latch_bit_in) | $past(timer_out)))
    else $error("pin level not latch or timer output");

  oe_level_a: assert property (1'b1 |=> timer_output_pin_oe_out == !$past(port_direction_bit_in)) // RL16
    else $error("pin enable does not follow direction bit");

  stopped_load_a: assert property (wr_secondary && !run |=> secondary_compare == $past(cpu_bus_in.wdata)) // RL7
    else $error("stopped write did not load compare");

  buffer_hold_a: assert property (run && wr_secondary |=> $stable(secondary_compare)) // RL7 RL8
    else $error("running write changed active compare");

  div1_tick_a: assert property (run && timer_control.clock_select_field == edct_pkg::CLK_DIV1 |=> tick) // RL11
    else $error("undivided clock missed a tick");

  div2_tick_a: assert property (run && tick && timer_control.clock_select_field == edct_pkg::CLK_DIV2 |=> // RL11
    !tick)
    else $error("halved clock ticked twice in a row");

  bad_clock_a: assert property (timer_control.clock_select_field > edct_pkg::CLK_COMPANION |=> !tick) // RL11
    else $error("prohibited clock code gave a tick");
endmodule : edct_timer

// ===== test/edct_timer_tb.sv
// Self-checking bench of the dual compare timer
module edct_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] AC = edct_pkg::ADDR_TIMER_CONTROL;
  localparam logic [15:0] AP = edct_pkg::ADDR_PRIMARY_COMPARE;
  localparam logic [15:0] AS = edct_pkg::ADDR_SECONDARY_COMPARE;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  edct_pkg::edct_bus_s bus = '0;
  logic comp = 1'b0;
  logic comp_run = 1'b0;
  logic dir = 1'b0;
  logic latch = 1'b0;
  logic [7:0] rdata;
  logic irq;
  logic pin;
  logic oe;
  logic [7:0] cur = 8'h00;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  int n_irq = 0;
  int seed = 35427;
  int divs[5] = '{1, 2, 4, 64, 1024};
  int n;
  int g;
  int base;
  edct_timer uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cpu_bus_in(bus), .companion_event_timer_in(comp),
    .port_direction_bit_in(dir), .port_latch_bit_in(latch), .cpu_rdata_out(rdata),
    .match_interrupt_out(irq), .timer_output_pin_out(pin), .timer_output_pin_oe_out(oe));
  always #5 clk_in = ~clk_in;
  // Companion output rises once every four cycles while enabled
  always @(posedge clk_in) comp <= comp_run & cycles[1];
  always @(negedge clk_in)
  begin
    cycles++;
    if (irq === 1'b1) n_irq++;
    if (cycles == 90000)
    begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk_in);
    bus <= '0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_in);
    bus <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk_in);
    bus <= '0;
    @(negedge clk_in);
    chk(rdata, e);
  endtask : rd
  // Stop with unchanged bits, set up, then start
  task automatic run(input logic [7:0] c, input logic [7:0] p, input logic [7:0] s);
    wr(AC, cur & 8'h7F);
    wr(AC, c);
    wr(AP, p);
    wr(AS, s);
    cur = c | 8'h80;
    wr(AC, cur);
    base = n_irq;
  endtask : run
  // Cycles between two successive match pulses
  task automatic gap(output int m);
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 30000)
    begin
      @(negedge clk_in);
      k++;
    end
    m = 0;
    do
    begin
      @(negedge clk_in);
      m++;
    end while (irq !== 1'b1 && m < 30000);
  endtask : gap
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(AC, edct_pkg::RESET_CONTROL);
    rd(AP, edct_pkg::RESET_COMPARE);
    rd(AS, edct_pkg::RESET_COMPARE);
    rd(16'hFF70, 8'h00);
    n = $random(seed);
    wr(AC, n[7:0] & 8'h7F);
    rd(AC, n[7:0] & 8'h7F);
    cur = n[7:0] & 8'h7F;
    $display("register test done");
    for (int s = 0; s < 5; s++)
    begin
      n = 3 + ($random(seed) & 3);
      run({1'b0, s[2:0], 4'h1}, n[7:0], 8'h01);
      gap(g);
      chk(g, (n + 1) * divs[s]);
    end
    $display("interval test done");
    for (int l = 0; l < 2; l++)
    begin
      run({6'h00, l[0], 1'b1}, 8'h04, 8'h00);
      gap(g);
      repeat (3) @(negedge clk_in);
      chk(pin, l[0] ^ n_irq[0] ^ base[0]);
    end
    @(posedge clk_in);
    latch <= 1'b1;
    dir <= 1'b1;
    repeat (3) @(negedge clk_in);
    chk({pin, oe}, 2'b10);
    @(posedge clk_in);
    latch <= 1'b0;
    dir <= 1'b0;
    wr(AC, cur & 8'h7F);
    wr(AC, 8'h01);
    cur = 8'h01;
    base = n_irq;
    repeat (40) @(negedge clk_in);
    chk(n_irq, base);
    chk(pin, 1'b0);
    chk(oe, 1'b1);
    $display("pin and stop test done");
    run(8'h09, 8'h07, 8'h02);
    gap(g);
    chk(g, 8);
    run(8'h05, 8'h09, 8'h03);
    gap(g);
    chk(g, 4);
    wr(AS, 8'h06);
    rd(AS, 8'h06);
    gap(g);
    gap(g);
    chk(g, 7);
    // Write lands on the edge of the next secondary match
    repeat (5) @(posedge clk_in);
    wr(AS, 8'h02);
    @(negedge clk_in);
    gap(g);
    chk(g, 7);
    gap(g);
    chk(g, 3);
    $display("pwm and carrier test done");
    comp_run <= 1'b1;
    run(8'h51, 8'h03, 8'h00);
    gap(g);
    chk(g, 16);
    $display("companion test done");
    // Mode without clearing match lets the counter wrap
    run(8'h0D, 8'h10, 8'h00);
    gap(g);
    chk(g, 256);
    $display("wrap test done");
    finish_test();
  end
endmodule : edct_timer_tb
